// file: hw/an_regs.sv
// Negotiation expansion, next-page and gigabit control registers behind AXI4-Lite.
// Assumes the negotiation engine runs on aclk and pulses its event strobes.
//
// Added by the designer: the AXI4-Lite interface to the registers.
module an_regs (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Negotiation engine
    input wire an_regs_pkg::link_in_t evt,
    output an_regs_pkg::cfg_out_t cfg,
    // Interrupt
    output logic irq
);
    import an_regs_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] partner_base_q, partner_base_d, rx_np_q, rx_np_d;
    logic [15:0] tx_np_q, tx_np_d, ctrl_q, ctrl_d;
    logic toggle_q, toggle_d, pd_fault_q, pd_fault_d, page_rx_q, page_rx_d;
    logic [2:0] sts_q, sts_d, msk_q, msk_d;
    logic irq_q, irq_d;
    cfg_out_t cfg_q, cfg_d;
    wr_state_t wst_q, wst_d;
    logic aw_got_q, aw_got_d, w_got_q, w_got_d, awrdy_q, awrdy_d, wrdy_q, wrdy_d;
    logic [7:0] widx_q, widx_d;
    logic [15:0] wdat_q, wdat_d;
    logic [1:0] wstb_q, wstb_d, bresp_q, bresp_d, rresp_q, rresp_d;
    logic arrdy_q, arrdy_d, rvalid_q, rvalid_d, bvalid_q, bvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_fire, rd_fire, rd_exp, rd_sts;
    logic [7:0] ridx;

    // Merge byte lanes into a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [15:0] nw, input logic [1:0] stb);
        merge = {stb[1] ? nw[15:8] : old[15:8], stb[0] ? nw[7:0] : old[7:0]};
    endfunction

    // Any index outside the group answers with an error
    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx >= IDX_PARTNER_BASE) && (idx <= IDX_IRQ_MSK);
    endfunction

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    assign wr_fire = aw_got_q && w_got_q && (wst_q == WR_IDLE);
    assign rd_fire = arvalid && arrdy_q;
    assign ridx = araddr[9:2];
    assign rd_exp = rd_fire && (ridx == IDX_EXPAND);
    assign rd_sts = rd_fire && (ridx == IDX_IRQ_STS);

    // Address and data are caught in either order, then one write retires
    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        widx_d = widx_q;
        wdat_d = wdat_q;
        wstb_d = wstb_q;
        wst_d = wst_q;
        bresp_d = bresp_q;
        if (awvalid && awrdy_q) begin
            aw_got_d = 1'b1;
            widx_d = awaddr[9:2];
        end
        if (wvalid && wrdy_q) begin
            w_got_d = 1'b1;
            wdat_d = wdata[15:0];
            wstb_d = wstrb[1:0];
        end
        if (wr_fire) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            wst_d = WR_RESP;
            bresp_d = mapped(widx_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (wst_q == WR_RESP && bready) begin
            wst_d = WR_IDLE;
        end
        // Ready drops while a request waits, so payloads are never overwritten
        awrdy_d = !aw_got_d && (wst_d == WR_IDLE);
        wrdy_d = !w_got_d && (wst_d == WR_IDLE);
        // Response valid kept in its own flop so the pin is a register output
        bvalid_d = (wst_d == WR_RESP);
        arrdy_d = !(rvalid_q && !rready) && !rd_fire;
        rvalid_d = rd_fire || (rvalid_q && !rready);
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rd_fire) begin
            rresp_d = mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
            rdata_d = 32'h0000_0000;
            if (ridx == IDX_PARTNER_BASE) begin
                rdata_d[15:0] = partner_base_q;
            end else if (ridx == IDX_EXPAND) begin
                rdata_d[EXP_PD_FAULT] = pd_fault_q;
                rdata_d[EXP_PARTNER_NP] = evt.partner_np_capable;
                rdata_d[EXP_LOC_NP] = 1'b1;
                rdata_d[EXP_PAGE_RX] = page_rx_q;
                rdata_d[EXP_PARTNER_AN] = evt.partner_an_capable;
            end else if (ridx == IDX_TX_NP) begin
                rdata_d[15:0] = tx_np_q;
                rdata_d[TXNP_TOGGLE] = toggle_q;
            end else if (ridx == IDX_RX_NP) begin
                rdata_d[15:0] = rx_np_q;
            end else if (ridx == IDX_GIG_CTRL) begin
                rdata_d[15:0] = ctrl_q;
            end else if (ridx == IDX_IRQ_STS) begin
                rdata_d[2:0] = sts_q;
            end else if (ridx == IDX_IRQ_MSK) begin
                rdata_d[2:0] = msk_q;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_q <= WR_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awrdy_q <= 1'b0;
            wrdy_q <= 1'b0;
            widx_q <= 8'h00;
            wdat_q <= RST_ZERO;
            wstb_q <= 2'h0;
            bresp_q <= RESP_OKAY;
            bvalid_q <= 1'b0;
            arrdy_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else begin
            wst_q <= wst_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awrdy_q <= awrdy_d;
            wrdy_q <= wrdy_d;
            widx_q <= widx_d;
            wdat_q <= wdat_d;
            wstb_q <= wstb_d;
            bresp_q <= bresp_d;
            bvalid_q <= bvalid_d;
            arrdy_q <= arrdy_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    // Hardware set beats the read clear, so no event is lost in the read cycle
    always_comb begin
        partner_base_d = evt.base_valid ? (evt.base_word & BASE_MASK) : partner_base_q;
        rx_np_d = evt.np_valid ? evt.np_word : rx_np_q;
        toggle_d = evt.tx_sent ? !evt.tx_toggle : toggle_q;
        pd_fault_d = evt.pd_fault || (pd_fault_q && !rd_exp);
        page_rx_d = evt.np_valid || (page_rx_q && !rd_exp);
        sts_d = (sts_q & {3{!rd_sts}}) | {evt.pd_fault, evt.np_valid, evt.base_valid};
        msk_d = msk_q;
        tx_np_d = tx_np_q;
        ctrl_d = ctrl_q;
        if (wr_fire && widx_q == IDX_TX_NP) begin
            tx_np_d = merge(tx_np_q, wdat_q, wstb_q) & TXNP_WMASK;
        end else if (wr_fire && widx_q == IDX_GIG_CTRL) begin
            ctrl_d = merge(ctrl_q, wdat_q, wstb_q);
        end else if (wr_fire && widx_q == IDX_IRQ_MSK) begin
            msk_d = wstb_q[0] ? wdat_q[2:0] : msk_q;
        end
        irq_d = |(sts_d & msk_d);
        // Test modes are passed on as written; reserved codes are not filtered
        cfg_d.test_mode = ctrl_d[15:13];
        cfg_d.force_master = ctrl_d[CTRL_MS_MAN] && ctrl_d[CTRL_MS_VAL];
        cfg_d.force_slave = ctrl_d[CTRL_MS_MAN] && !ctrl_d[CTRL_MS_VAL];
        cfg_d.multi_port = ctrl_d[10];
        cfg_d.adv_fdx = ctrl_d[9];
        cfg_d.adv_hdx = ctrl_d[8];
        cfg_d.tx_page = tx_np_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            partner_base_q <= RST_ZERO;
            rx_np_q <= RST_ZERO;
            tx_np_q <= RST_TXNP;
            ctrl_q <= RST_CTRL;
            toggle_q <= 1'b0;
            pd_fault_q <= 1'b0;
            page_rx_q <= 1'b0;
            sts_q <= RST_IRQ;
            msk_q <= RST_IRQ;
            irq_q <= 1'b0;
            cfg_q <= {RST_CTRL[15:13], 2'h0, RST_CTRL[10:8], RST_TXNP};
        end else begin
            partner_base_q <= partner_base_d;
            rx_np_q <= rx_np_d;
            tx_np_q <= tx_np_d;
            ctrl_q <= ctrl_d;
            toggle_q <= toggle_d;
            pd_fault_q <= pd_fault_d;
            page_rx_q <= page_rx_d;
            sts_q <= sts_d;
            msk_q <= msk_d;
            irq_q <= irq_d;
            cfg_q <= cfg_d;
        end
    end

    // Outputs
    assign awready = awrdy_q;
    assign wready = wrdy_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arrdy_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign cfg = cfg_q;
    assign irq = irq_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_exp_read;
        rd_fire && ridx == IDX_EXPAND;
    endsequence
    sequence s_both_held;
        aw_got_q && w_got_q && !bvalid;
    endsequence

    chk_base_capture: assert property (
        evt.base_valid |=> partner_base_q == ($past(evt.base_word) & BASE_MASK))
        else $error("partner base page not captured");
    chk_pd_latch: assert property (
        evt.pd_fault ##1 !rd_exp [*2] |-> pd_fault_q)
        else $error("parallel fault not held");
    chk_page_latch: assert property (
        evt.np_valid |=> page_rx_q)
        else $error("page received flag not set");
    chk_exp_word: assert property (
        s_exp_read |=> rdata[15:5] == 11'h000 && rdata[2] && rdata[0] == $past(evt.partner_an_capable)
        && rdata[3] == $past(evt.partner_np_capable))
        else $error("expansion read wrong");
    chk_latch_clear: assert property (
        s_exp_read ##0 !evt.pd_fault |=> !pd_fault_q)
        else $error("fault flag not cleared by read");
    chk_toggle_flip: assert property (
        evt.tx_sent |=> toggle_q == !$past(evt.tx_toggle))
        else $error("toggle not complement of sent");
    chk_np_capture: assert property (
        evt.np_valid |=> rx_np_q == $past(evt.np_word))
        else $error("received page not captured");
    chk_force_role: assert property (
        cfg.force_master == (ctrl_q[CTRL_MS_MAN] && ctrl_q[CTRL_MS_VAL]) &&
        !(cfg.force_master && cfg.force_slave))
        else $error("master slave force wrong");
    chk_write_resp: assert property (
        s_both_held |=> bvalid)
        else $error("write response missing");
    chk_irq_level: assert property (
        irq == |(sts_q & msk_q))
        else $error("interrupt level wrong");

    // Full-word writes; partial lanes are left to the bench
    sequence s_tx_write;
        wr_fire && widx_q == IDX_TX_NP && wstb_q == 2'h3;
    endsequence
    sequence s_ctrl_write;
        wr_fire && widx_q == IDX_GIG_CTRL && wstb_q == 2'h3;
    endsequence

    chk_tx_write: assert property (
        s_tx_write |=> tx_np_q == ($past(wdat_q) & TXNP_WMASK))
        else $error("transmit page write wrong");
    chk_ctrl_write: assert property (
        s_ctrl_write |=> ctrl_q == $past(wdat_q) && cfg.test_mode == $past(wdat_q[15:13]))
        else $error("control write wrong");
    chk_ro_base: assert property (
        wr_fire && widx_q == IDX_PARTNER_BASE && !evt.base_valid |=> $stable(partner_base_q))
        else $error("partner base page changed by write");
    chk_page_clear: assert property (
        s_exp_read ##0 !evt.np_valid |=> !page_rx_q)
        else $error("page flag not cleared by read");
    chk_unmapped_read: assert property (
        rd_fire && !mapped(ridx) |=> rvalid && rresp == RESP_SLVERR)
        else $error("unmapped read not refused");

endmodule

// file: include/an_regs_pkg.sv
// Constants, field positions and carriers for the negotiation register group.
// Assumes one clock domain shared with the negotiation engine that feeds it.
//
// What this block does
// - The partner ability register is read-only, holds the partner base page with bit 12 cleared and resets to zero.
// - The parallel detection fault flag at expansion bit 4 latches high and resets to 0.
// - The page-received flag at expansion bit 1 latches on a new page and resets to 0.
// - Expansion bit 3 shows partner next-page ability, bit 0 partner autonegotiation, 15:5 zero.
// - Expansion bit 2 reads 1, the local side supports next pages.
// - The transmit next-page register has writable bits 15, 13, 12 and 10:0 with reset 0x2001.
// - Transmit toggle bit 11 is read-only, the complement of the last sent toggle, reset 0.
// - The received next-page register is read-only, captures the partner page, resets to zero.
// - Control bits 15:13 select the transmitter test mode, codes 101 to 111 reserved.
// - Control bit 12 enables manual master/slave, bit 11 counts only while it is set, both 0.
// - With manual mode on, bit 11 at 1 forces master and at 0 forces slave.
// - Control bits 10, 9, 8 give port type and gigabit duplex, reset 1; bits 7:0 reset 0x00.
package an_regs_pkg;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PARTNER_BASE = 8'h05;
    localparam logic [7:0] IDX_EXPAND = 8'h06;
    localparam logic [7:0] IDX_TX_NP = 8'h07;
    localparam logic [7:0] IDX_RX_NP = 8'h08;
    localparam logic [7:0] IDX_GIG_CTRL = 8'h09;
    localparam logic [7:0] IDX_IRQ_STS = 8'h0A;
    localparam logic [7:0] IDX_IRQ_MSK = 8'h0B;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int EXP_PD_FAULT = 4;
    localparam int EXP_PARTNER_NP = 3;
    localparam int EXP_LOC_NP = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_PARTNER_AN = 0;
    localparam int TXNP_TOGGLE = 11;
    localparam int CTRL_MS_MAN = 12;
    localparam int CTRL_MS_VAL = 11;
    localparam logic [15:0] BASE_MASK = 16'hEFFF;
    localparam logic [15:0] TXNP_WMASK = 16'hB7FF;
    localparam logic [15:0] RST_TXNP = 16'h2001;
    localparam logic [15:0] RST_CTRL = 16'h0700;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [2:0] RST_IRQ = 3'h0;
    localparam int IRQ_BASE = 0;
    localparam int IRQ_PAGE = 1;
    localparam int IRQ_PD = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_t;

    // Events and levels from the negotiation engine, same clock
    typedef struct packed {
        logic base_valid;
        logic [15:0] base_word;
        logic np_valid;
        logic [15:0] np_word;
        logic pd_fault;
        logic partner_np_capable;
        logic partner_an_capable;
        logic tx_sent;
        logic tx_toggle;
    } link_in_t;

    // Settings towards the negotiation engine and transmitter
    typedef struct packed {
        logic [2:0] test_mode;
        logic force_master;
        logic force_slave;
        logic multi_port;
        logic adv_fdx;
        logic adv_hdx;
        logic [15:0] tx_page;
    } cfg_out_t;

endpackage

// file: tb/an_link_model.sv
// Behavioural far-end partner that feeds the negotiation event strobes.
// Assumes it shares aclk with the register block; the bench calls its tasks.
module an_link_model
    import an_regs_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Engine events
    output link_in_t evt
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle at time zero: no strobes, partner shows no abilities
    initial begin
        evt = '0;
    end

    // One-cycle strobe; words go to their inverse after it, so stale data never passes
    task automatic send(input int k, input logic [15:0] w);
        @(posedge aclk);
        evt.base_valid <= (k == 0);
        evt.np_valid <= (k == 1);
        evt.pd_fault <= (k == 2);
        evt.tx_sent <= (k == 3);
        evt.base_word <= w;
        evt.np_word <= w;
        evt.tx_toggle <= w[0];
        @(posedge aclk);
        evt.base_valid <= 1'b0;
        evt.np_valid <= 1'b0;
        evt.pd_fault <= 1'b0;
        evt.tx_sent <= 1'b0;
        evt.base_word <= ~w;
        evt.np_word <= ~w;
        evt.tx_toggle <= ~w[0];
    endtask

    // Live partner abilities, changed right after an edge
    task automatic caps(input logic np, input logic an);
        @(posedge aclk);
        evt.partner_np_capable <= np;
        evt.partner_an_capable <= an;
    endtask
endmodule

// file: tb/an_regs_tb.sv
// Self-checking bench for the negotiation register group.
// Assumes the partner model in an_link_model and a single 200 MHz clock.
module an_regs_tb;
    import an_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd_v;
    logic [3:0] wstrb = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] w;
    link_in_t evt;
    cfg_out_t cfg;
    int err_total = 0;
    int comparisons = 0;

    // Clock
    always #2.5 aclk = ~aclk;

    an_regs i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .evt(evt), .cfg(cfg), .irq(irq));
    an_link_model i_link (.aclk(aclk), .evt(evt));

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Expected engine settings from a control word and a transmit page
    function automatic logic [31:0] exp_cfg(input logic [15:0] c, input logic [15:0] t);
        exp_cfg = {8'h00, c[15:13], c[12] & c[11], c[12] & ~c[11], c[10:8], t & TXNP_WMASK};
    endfunction

    // Transmit page read value: bit 11 is the complement of the last sent toggle
    function automatic logic [31:0] exp_tx(input logic [15:0] d, input logic sent);
        exp_tx = {16'h0, d & TXNP_WMASK};
        exp_tx[11] = ~sent;
    endfunction

    // Address and data offered together, each released when taken; no fixed latency assumed
    task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= {22'h0, idx, 2'h0};
        wdata <= {16'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 50) begin
            @(posedge aclk);
            n++;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        if (n >= 50) chk(32'h1, 32'h0, "write hang");
    endtask

    task automatic rd(input logic [7:0] idx);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= {22'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 50) begin
            @(posedge aclk);
            n++;
            if (rvalid) begin
                rd_v = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
            if (arvalid && arready) arvalid <= 1'b0;
        end
        if (n >= 50) chk(32'h1, 32'h0, "read hang");
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        chk(32'h1, 32'h0, "watchdog");
        tally_and_finish;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(89));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(IDX_PARTNER_BASE);
        chk(rd_v, 32'h0, "base reset");
        chk(32'(resp), 32'(RESP_OKAY), "mapped read response");
        rd(IDX_EXPAND); chk(rd_v, 32'h4, "expansion reset");
        rd(IDX_TX_NP); chk(rd_v, {16'h0, RST_TXNP}, "tx page reset");
        rd(IDX_RX_NP); chk(rd_v, 32'h0, "rx page reset");
        rd(IDX_GIG_CTRL); chk(rd_v, {16'h0, RST_CTRL}, "control reset");
        chk(32'(cfg), exp_cfg(RST_CTRL, RST_TXNP), "cfg reset");
        // Unmapped and read-only places
        rd(8'h03); chk(rd_v, 32'h0, "unmapped data");
        chk(32'(resp), 32'(RESP_SLVERR), "unmapped read");
        wr(8'h03, 16'hFFFF);
        chk(32'(resp), 32'(RESP_SLVERR), "unmapped write");
        wr(IDX_PARTNER_BASE, 16'hFFFF);
        chk(32'(resp), 32'(RESP_OKAY), "read-only write response");
        rd(IDX_PARTNER_BASE);
        chk(rd_v, 32'h0, "base is read-only");
        wr(IDX_RX_NP, 16'hFFFF); rd(IDX_RX_NP); chk(rd_v, 32'h0, "rx is read-only");
        // Random partner pages; page flag latches until read
        repeat (4) begin
            w = 16'($urandom);
            i_link.send(0, w);
            rd(IDX_PARTNER_BASE);
            chk(rd_v, {16'h0, w & BASE_MASK}, "base page");
            w = 16'($urandom);
            i_link.send(1, w);
            rd(IDX_RX_NP); chk(rd_v, {16'h0, w}, "rx page");
            rd(IDX_EXPAND); chk(32'(rd_v[1]), 32'h1, "page flag set");
            rd(IDX_EXPAND); chk(32'(rd_v[1]), 32'h0, "page flag cleared");
        end
        // Fault latch beside live abilities
        i_link.caps(1'b1, 1'b1);
        i_link.send(2, 16'h0);
        rd(IDX_EXPAND); chk(rd_v, 32'h1D, "fault latched");
        rd(IDX_EXPAND); chk(rd_v, 32'h0D, "fault cleared");
        i_link.caps(1'b0, 1'b0);
        rd(IDX_EXPAND); chk(rd_v, 32'h04, "abilities live");
        // Transmit page with both toggle values sent
        for (int i = 0; i < 2; i++) begin
            w = 16'($urandom);
            wr(IDX_TX_NP, w);
            i_link.send(3, 16'(i));
            chk(32'(cfg.tx_page), 32'(w & TXNP_WMASK), "tx page out");
            rd(IDX_TX_NP);
            chk(rd_v, exp_tx(w, i[0]), "toggle");
        end
        // Every test mode code; manual master/slave stays off here
        for (int i = 0; i < 8; i++) begin
            w = {i[2:0], 13'h0700};
            wr(IDX_GIG_CTRL, w);
            chk(32'(cfg.test_mode), 32'(i[2:0]), "test mode");
            rd(IDX_GIG_CTRL); chk(rd_v, {16'h0, w}, "control readback");
        end
        // Manual master/slave combinations with random ability bits
        for (int i = 0; i < 4; i++) begin
            w = {3'h0, i[1], i[0], 11'($urandom)};
            wr(IDX_GIG_CTRL, w);
            chk(32'({cfg.force_master, cfg.force_slave}), 32'({i[1] & i[0], i[1] & ~i[0]}),
                "manual role");
            chk(32'({cfg.multi_port, cfg.adv_fdx, cfg.adv_hdx}), 32'(w[10:8]), "abilities");
            rd(IDX_GIG_CTRL); chk(rd_v, {16'h0, w}, "control bits");
        end
        // Upper byte lane alone; the lower byte keeps the last value
        wr(IDX_GIG_CTRL, 16'h0000, 4'h2);
        rd(IDX_GIG_CTRL);
        chk(rd_v, {24'h0, w[7:0]}, "upper lane only");
        // Interrupt raised, cleared by read, then masked
        rd(IDX_IRQ_STS);
        wr(IDX_IRQ_MSK, 16'h0004);
        i_link.send(2, 16'h0);
        repeat (3) @(posedge aclk);
        chk(32'(irq), 32'h1, "irq raised");
        rd(IDX_IRQ_STS); chk(rd_v, 32'h4, "irq status");
        repeat (3) @(posedge aclk);
        chk(32'(irq), 32'h0, "irq cleared");
        i_link.send(1, 16'h1234);
        repeat (3) @(posedge aclk);
        chk(32'(irq), 32'h0, "irq masked");
        rd(IDX_IRQ_STS); chk(rd_v, 32'h2, "masked status");
        tally_and_finish;
    end
endmodule
